// ### rtl/sdp_map.svh
// Constants for the stereo serial converter port
`ifndef SDP_MAP_SVH
`define SDP_MAP_SVH
`define SDP_CLK_HZ 100000000
`define SDP_BCLK_HZ 2116800
// Half bit period in system cycles, rounded down so the bit rate never falls below target
`define SDP_HALF_CYC (`SDP_CLK_HZ / (2 * `SDP_BCLK_HZ))
`define SDP_SLOT_BITS 24
`define SDP_DAC_DELAY 8
`define SDP_ADC_DELAY 4
`define SDP_WORD_BITS 16
`define SDP_NARROW_BITS 8
`define SDP_ADDR_W 9
`endif

// ### rtl/sdp_pkg.sv
// Types for the stereo serial converter port
package sdp_pkg;
    typedef struct packed {
        logic req;
        logic [8:0] addr;
        logic [15:0] wdata;
    } sdp_dma_req_t;
    typedef struct packed {
        logic ack;
        logic [15:0] rdata;
    } sdp_dma_rsp_t;
endpackage : sdp_pkg

// ### rtl/sdp_serial_port.sv
// Stereo serial converter port: playback DAC shifter, record ADC shifter, DMA word exchange
// Summary of operation
// - Playback word latch of 16 bits is loaded only by DMA.
// - Each half sample, latch goes to shift register; left then right.
// - Playback bits MSB first, changed on falling bit clock edge.
// - First playback bit driven 8 bit clocks after word clock edge.
// - Each channel slot is 24 bit clocks; stereo sample is 48.
// - One DMA request per channel slot, twice per sample.
// - Bit clock 100 MHz / 46, about 2.174 MHz, against a 2.1168 MHz target for 44.1 kHz stereo rate.
// - Record word is 16 bits when width select high, else 8.
// - Full record word goes to a latch and out by DMA.
// - Record path runs on the same slot timing as playback.
// - Record write shares the playback read DMA cycle and word.
// - Left words go to even addresses, right words to odd.
// - Narrow record samples sit in upper byte, lower byte zero.
// - Record bits MSB first, sampled on rising record bit clock.
// - Record bit clock bursts 8 or 16 pulses per channel, else idle.
// - Burst starts 4 bit clocks after channel select toggles every 24.
`timescale 1ns/1ns
`include "sdp_map.svh"
module sdp_serial_port (
    input wire logic i_clk,                            // System clock 100 MHz
    input wire logic i_rst_b,                          // Async reset, active low
    input wire logic i_enable,                         // Run the converters
    input wire logic i_record_width_select,            // High: 16-bit record
    input wire logic i_record_serial_in,               // ADC serial data pin
    input wire sdp_pkg::sdp_dma_rsp_t i_dma_rsp,       // DMA acknowledge and read data
    output logic o_playback_serial_out,                // DAC serial data
    output logic o_playback_bit_clock,                 // DAC bit clock
    output logic o_playback_word_clock,                // DAC word clock, low = left
    output logic o_record_bit_clock,                   // Gated ADC bit clock
    output logic o_record_channel_select,              // ADC channel, low = left
    output sdp_pkg::sdp_dma_req_t o_dma_req            // DMA request, address, write data
);
    localparam int HALF = `SDP_HALF_CYC;
    localparam logic [4:0] SLOT_LAST = 5'(`SDP_SLOT_BITS - 1);
    localparam logic [4:0] DAC_DLY = 5'(`SDP_DAC_DELAY);
    localparam logic [4:0] ADC_DLY = 5'(`SDP_ADC_DELAY);
    // Both paths count the same bit cells, so record and playback never drift apart

    // ----------------------------------------
    // Input synchroniser
    // ----------------------------------------
    logic [2:0] din_sync_reg;
    logic [2:0] din_sync_next;
    logic din_reg;
    logic din_next;
    always_comb begin
        din_sync_next = {din_sync_reg[1:0], i_record_serial_in};
        din_next = (din_sync_reg[1] == din_sync_reg[2]) ? din_sync_reg[2] : din_reg;
    end
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            din_sync_reg <= 3'h0;
            din_reg <= 1'b0;
        end else begin
            din_sync_reg <= din_sync_next;
            din_reg <= din_next;
        end
    end

    // ----------------------------------------
    // Bit clock divider and slot counters
    // ----------------------------------------
    logic [5:0] div_reg;
    logic [5:0] div_next;
    logic phase_reg;                 // Bit clock level
    logic phase_next;
    logic [4:0] bit_reg;             // Bit index within slot
    logic [4:0] bit_next;
    logic chan_reg;                  // 0 left, 1 right
    logic chan_next;
    logic rise_en;
    logic fall_en;
    logic slot_start;
    always_comb begin
        div_next = div_reg;
        phase_next = phase_reg;
        bit_next = bit_reg;
        chan_next = chan_reg;
        rise_en = 1'b0;
        fall_en = 1'b0;
        if (i_enable) begin
            if (div_reg == 6'(HALF - 1)) begin
                div_next = 6'h00;
                phase_next = ~phase_reg;
                rise_en = ~phase_reg;
                fall_en = phase_reg;
            end else begin
                div_next = div_reg + 6'h01;
            end
            if (fall_en) begin
                // Falling edge ends a bit cell
                if (bit_reg == SLOT_LAST) begin
                    bit_next = 5'h00;
                    chan_next = ~chan_reg;
                end else begin
                    bit_next = bit_reg + 5'h01;
                end
            end
        end
    end
    assign slot_start = fall_en && (bit_reg == SLOT_LAST);
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            div_reg <= 6'h00;
            phase_reg <= 1'b0;
            bit_reg <= 5'h00;
            chan_reg <= 1'b0;
        end else begin
            div_reg <= div_next;
            phase_reg <= phase_next;
            bit_reg <= bit_next;
            chan_reg <= chan_next;
        end
    end

    // ----------------------------------------
    // Playback and record datapath, DMA
    // ----------------------------------------
    logic [15:0] out_latch_reg;
    logic [15:0] out_latch_next;
    logic [15:0] out_shift_reg;
    logic [15:0] out_shift_next;
    logic [15:0] in_shift_reg;
    logic [15:0] in_shift_next;
    logic [15:0] in_latch_reg;
    logic [15:0] in_latch_next;
    logic in_chan_reg;
    logic in_chan_next;
    logic [7:0] page_reg;            // Upper address bits, advance per stereo sample
    logic [7:0] page_next;
    logic sdo_reg;
    logic sdo_next;
    logic adc_clk_reg;
    logic adc_clk_next;
    sdp_pkg::sdp_dma_req_t dma_reg;
    sdp_pkg::sdp_dma_req_t dma_next;
    logic [4:0] rec_len;
    logic in_burst;
    always_comb begin
        rec_len = i_record_width_select ? 5'(`SDP_WORD_BITS) : 5'(`SDP_NARROW_BITS);
        in_burst = (bit_reg >= ADC_DLY) && (bit_reg < ADC_DLY + rec_len);
        out_latch_next = out_latch_reg;
        out_shift_next = out_shift_reg;
        in_shift_next = in_shift_reg;
        in_latch_next = in_latch_reg;
        in_chan_next = in_chan_reg;
        page_next = page_reg;
        sdo_next = sdo_reg;
        adc_clk_next = adc_clk_reg;
        dma_next = dma_reg;
        if (i_dma_rsp.ack && dma_reg.req) begin
            out_latch_next = i_dma_rsp.rdata;
            dma_next.req = 1'b0;
        end
        if (i_enable) begin
            if (slot_start) begin
                out_shift_next = out_latch_reg;
                // One combined read-modify-write per slot
                dma_next.req = 1'b1;
                // Word of the slot just ended: its record word and next playback word share parity
                dma_next.addr = {page_reg, chan_reg};
                dma_next.wdata = in_latch_reg;
                if (chan_reg) begin
                    page_next = page_reg + 8'h01;
                end
            end
            if (fall_en) begin
                // Bit k of the slot is presented after the falling edge ending bit k-1
                if (bit_next >= DAC_DLY && bit_next < DAC_DLY + 5'(`SDP_WORD_BITS)) begin
                    sdo_next = out_shift_next[15];
                    out_shift_next = {out_shift_next[14:0], 1'b0};
                end else begin
                    sdo_next = 1'b0;
                end
                adc_clk_next = 1'b0;
            end
            if (rise_en && in_burst) begin
                adc_clk_next = 1'b1;
                in_shift_next = {in_shift_reg[14:0], din_reg};
                if (bit_reg == ADC_DLY + rec_len - 5'h01) begin
                    // Full word; narrow words land in the upper byte
                    in_latch_next = i_record_width_select ? {in_shift_reg[14:0], din_reg}
                                                          : {in_shift_reg[6:0], din_reg, 8'h00};
                    in_chan_next = chan_reg;
                end
            end
        end else begin
            adc_clk_next = 1'b0;
        end
    end
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            out_latch_reg <= 16'h0000;
            out_shift_reg <= 16'h0000;
            in_shift_reg <= 16'h0000;
            in_latch_reg <= 16'h0000;
            in_chan_reg <= 1'b0;
            page_reg <= 8'h00;
            sdo_reg <= 1'b0;
            adc_clk_reg <= 1'b0;
            dma_reg <= '0;
        end else begin
            out_latch_reg <= out_latch_next;
            out_shift_reg <= out_shift_next;
            in_shift_reg <= in_shift_next;
            in_latch_reg <= in_latch_next;
            in_chan_reg <= in_chan_next;
            page_reg <= page_next;
            sdo_reg <= sdo_next;
            adc_clk_reg <= adc_clk_next;
            dma_reg <= dma_next;
        end
    end

    assign o_playback_serial_out = sdo_reg;
    assign o_playback_bit_clock = phase_reg;
    assign o_playback_word_clock = chan_reg;
    assign o_record_bit_clock = adc_clk_reg;
    assign o_record_channel_select = chan_reg;
    assign o_dma_req = dma_reg;

    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rst_b);

    // ----------------------------------------
    // Slot timing checks
    // ----------------------------------------
    slot_length_a: assert property (slot_start |-> bit_reg == 5'd23)
        else $error("slot not 24 bits");
    bit_range_a: assert property (bit_reg <= SLOT_LAST)
        else $error("bit index past slot");
    half_period_a: assert property (div_reg < 6'(HALF))
        else $error("divider past half period");
    wclk_slot_a: assert property ($changed(o_playback_word_clock) |-> $past(slot_start))
        else $error("word clock off slot");
    wclk_left_a: assert property (slot_start && chan_reg |=> !o_playback_word_clock)
        else $error("word clock not low at left");

    // ----------------------------------------
    // Playback checks
    // ----------------------------------------
    shift_load_a: assert property (slot_start |=> out_shift_reg == $past(out_latch_reg))
        else $error("shift register not loaded");
    tail_zero_a: assert property (slot_start |=> !o_playback_serial_out)
        else $error("dac data at slot start");
    dac_lead_a: assert property (bit_reg < 5'd8 && bit_reg != 5'd0 |-> !o_playback_serial_out)
        else $error("dac bit before delay");
    change_fall_a: assert property ($changed(o_playback_serial_out) |-> $fell(o_playback_bit_clock))
        else $error("dac data not on falling edge");

    // ----------------------------------------
    // Record checks
    // ----------------------------------------
    sync_agree_a: assert property (din_sync_reg[1] == din_sync_reg[2] |=> din_reg == $past(din_sync_reg[2]))
        else $error("synchroniser did not settle");
    narrow_low_a: assert property (!i_record_width_select && $changed(in_latch_reg) |-> in_latch_reg[7:0] == 8'h00)
        else $error("narrow low byte not zero");
    quiet_lead_a: assert property (bit_reg < 5'd4 |-> !o_record_bit_clock)
        else $error("record clock early");
    burst_end_a: assert property (bit_reg >= 5'd20 |-> !o_record_bit_clock)
        else $error("record clock late");
    burst_gate_a: assert property ($rose(o_record_bit_clock) |-> $past(in_burst))
        else $error("record clock outside burst");
    rec_rise_a: assert property ($rose(o_record_bit_clock) |-> $rose(o_playback_bit_clock))
        else $error("record clock off bit timing");
    freeze_a: assert property (!i_enable |=> !o_record_bit_clock)
        else $error("record clock while stopped");
    record_chan_a: assert property (slot_start |-> in_chan_reg == chan_reg)
        else $error("record word from wrong channel");

    // ----------------------------------------
    // DMA checks
    // ----------------------------------------
    dma_per_slot_a: assert property (slot_start |=> dma_reg.req)
        else $error("no dma at slot");
    req_rise_a: assert property ($rose(dma_reg.req) |-> $past(slot_start))
        else $error("dma request off slot");
    dma_hold_a: assert property (dma_reg.req && !i_dma_rsp.ack && !slot_start |=> dma_reg.req && $stable(dma_reg.addr))
        else $error("dma request dropped early");
    ack_drop_a: assert property (i_dma_rsp.ack && dma_reg.req && !slot_start |=> !dma_reg.req)
        else $error("dma request held after ack");
    addr_parity_a: assert property (slot_start |=> dma_reg.addr[0] == $past(chan_reg))
        else $error("address parity wrong");
    page_step_a: assert property (slot_start && chan_reg |=> page_reg == $past(page_reg) + 8'h01)
        else $error("page not advanced");
    write_data_a: assert property (slot_start |=> dma_reg.wdata == $past(in_latch_reg))
        else $error("record word not written");
    latch_dma_a: assert property (i_dma_rsp.ack && dma_reg.req |=> out_latch_reg == $past(i_dma_rsp.rdata))
        else $error("latch not loaded");

    left_c: cover property (slot_start && !chan_reg);
    right_c: cover property (slot_start && chan_reg);
    narrow_c: cover property (!i_record_width_select && $changed(in_latch_reg));
    wide_c: cover property (i_record_width_select && $changed(in_latch_reg));
    ack_c: cover property (i_dma_rsp.ack && dma_reg.req);
endmodule : sdp_serial_port

// ### testbench/sdp_conv_model.sv
// External stereo serial DAC and ADC behaviour for the serial port bench
`timescale 1ns/1ns
module sdp_conv_model (
    input wire logic i_dac_data, // Playback serial data
    input wire logic i_dac_bclk, // Playback bit clock
    input wire logic i_dac_wclk, // Playback word clock
    input wire logic i_adc_bclk, // Gated record bit clock
    input wire logic i_adc_sel, // Record channel select
    input wire logic i_wide, // 16-bit record mode
    input wire logic [15:0] i_left, // Left input sample
    input wire logic [15:0] i_right, // Right input sample
    output logic o_adc_data, // Record serial data
    output logic [15:0] o_dac_word, // Word heard in last slot
    output int o_dac_rises, // Bit clocks in last slot
    output int o_adc_pulses // Record clocks in last channel
);
    int rises = 0;
    int pulses = 0;
    logic [15:0] shreg = 16'h0000;
    logic [15:0] sample = 16'h0000;
    initial begin
        o_adc_data = 1'b0;
        o_dac_word = 16'h0000;
        o_dac_rises = 0;
        o_adc_pulses = 0;
    end
    // Only the last 16 cells of a slot carry data
    always @(posedge i_dac_bclk) begin
        if (rises >= 8) shreg = {shreg[14:0], i_dac_data};
        rises = rises + 1;
    end
    always @(i_dac_wclk) begin
        o_dac_word = shreg;
        o_dac_rises = rises;
        rises = 0;
    end
    always @(i_adc_sel) begin
        o_adc_pulses = pulses;
        pulses = 0;
        sample = i_adc_sel ? i_right : i_left;
        o_adc_data = sample[15];
    end
    always @(posedge i_adc_bclk) pulses = pulses + 1;
    // Past the last bit the converter lets go; a moving level exposes late sampling
    always @(negedge i_adc_bclk) begin
        if (pulses >= (i_wide ? 16 : 8)) o_adc_data = ~o_adc_data;
        else o_adc_data = sample[15 - pulses];
    end
endmodule : sdp_conv_model

// ### testbench/testbench.sv
// Self-checking bench for the stereo serial converter port
`timescale 1ns/1ns
`include "sdp_map.svh"
module testbench;
    logic i_clk = 1'b0;
    logic i_rst_b = 1'b0;
    logic i_enable = 1'b0;
    logic i_width = 1'b0;
    sdp_pkg::sdp_dma_rsp_t rsp = '0;
    sdp_pkg::sdp_dma_req_t req;
    logic sdo, bclk, wclk, rclk, rsel, sdi;
    logic [15:0] dac_word;
    logic [15:0] left = 16'hC35A;
    logic [15:0] right = 16'h5AC3;
    logic [15:0] even_w = 16'h0000;
    logic [15:0] odd_w = 16'h0000;
    logic [15:0] acked = 16'h0000;
    int dac_rises, adc_pulses;
    int err_total = 0;
    int comparisons = 0;
    int req_count = 0;
    int slot_n = 0;
    always #5 i_clk = ~i_clk;
    sdp_serial_port dut_u (.i_clk(i_clk), .i_rst_b(i_rst_b), .i_enable(i_enable),
        .i_record_width_select(i_width), .i_record_serial_in(sdi), .i_dma_rsp(rsp),
        .o_playback_serial_out(sdo), .o_playback_bit_clock(bclk), .o_playback_word_clock(wclk),
        .o_record_bit_clock(rclk), .o_record_channel_select(rsel), .o_dma_req(req));
    sdp_conv_model model_u (.i_dac_data(sdo), .i_dac_bclk(bclk), .i_dac_wclk(wclk),
        .i_adc_bclk(rclk), .i_adc_sel(rsel), .i_wide(i_width), .i_left(left), .i_right(right),
        .o_adc_data(sdi), .o_dac_word(dac_word), .o_dac_rises(dac_rises), .o_adc_pulses(adc_pulses));
    // DMA memory answers one cycle after each request, with a word unique to the address
    always @(posedge i_clk) begin
        if (rsp.ack) rsp.ack <= 1'b0;
        else if (req.req === 1'b1) begin
            rsp.ack <= 1'b1;
            rsp.rdata <= {req.addr[0] ? 8'h96 : 8'h69, req.addr[8:1]};
        end
        if (rsp.ack && req.req === 1'b1) begin
            acked <= rsp.rdata;
            req_count++;
            if (req.addr[0]) odd_w <= req.wdata;
            else even_w <= req.wdata;
        end
    end
    task check(input logic [15:0] got, input logic [15:0] exp);
        comparisons++;
        if (got !== exp) begin
            err_total++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check
    task tally_and_finish;
        $display("comparisons %0d mismatches %0d", comparisons, err_total);
        if (err_total == 0 && comparisons > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask : tally_and_finish
    task wait_slot;
        logic w;
        int n;
        w = wclk;
        n = 0;
        while (wclk === w && n < 2000) begin
            @(negedge i_clk);
            n++;
        end
        slot_n = n;
        if (n >= 2000) begin
            err_total++;
            tally_and_finish;
        end
    endtask : wait_slot
    // Each slot plays the word fetched in the slot before it
    task play_words;
        logic [15:0] exp;
        int c0;
        wait_slot;
        wait_slot;
        exp = acked;
        c0 = req_count;
        repeat (4) begin
            wait_slot;
            check(dac_word, exp);
            check(16'(dac_rises), 16'h0018);
            check(16'(slot_n), 16'(2 * `SDP_SLOT_BITS * `SDP_HALF_CYC));
            exp = acked;
        end
        check(16'(req_count - c0), 16'h0004);
    endtask : play_words
    task record_words(input logic wide);
        logic [15:0] el, er;
        wait_slot;
        @(posedge i_clk);
        i_width <= wide;
        el = wide ? left : {left[15:8], 8'h00};
        er = wide ? right : {right[15:8], 8'h00};
        repeat (5) wait_slot;
        check(even_w, el);
        check(odd_w, er);
        check(16'(adc_pulses), wide ? 16'h0010 : 16'h0008);
    endtask : record_words
    initial begin
        repeat (8) @(posedge i_clk);
        i_rst_b <= 1'b1;
        i_enable <= 1'b1;
        play_words;
        record_words(1'b1);
        record_words(1'b0);
        tally_and_finish;
    end
endmodule : testbench
